// ==== acc_pkg.sv ====
// constants, register map and shared types of the analog compare control block
// assumes a 32-bit AHB-Lite bus with word-only transfers and one clock domain
package acc_pkg;

	localparam int ACC_DATA_W = 32;
	localparam int ACC_IDX_LSB = 2;
	localparam int ACC_IDX_W = 8;

	// register indices; byte address is four times the index
	localparam logic [7:0] ACC_IDX_CMP_CS = 8'h50;
	localparam logic [7:0] ACC_IDX_CONV_CS_B = 8'h7b;
	localparam logic [7:0] ACC_IDX_AUX = 8'h70;
	localparam logic [7:0] ACC_IDX_IRQ_STATUS = 8'h71;
	localparam logic [7:0] ACC_IDX_IRQ_MASK = 8'h72;

	// comparator control status fields
	localparam int ACC_CS_POWER_OFF = 7;
	localparam int ACC_CS_BANDGAP = 6;
	localparam int ACC_CS_OUT = 5;
	localparam int ACC_CS_FLAG = 4;
	localparam int ACC_CS_IRQ_EN = 3;
	localparam int ACC_CS_CAPTURE = 2;
	localparam int ACC_CS_MODE_HI = 1;
	localparam int ACC_CS_MODE_LO = 0;
	localparam logic [7:0] ACC_CS_RESET = 8'h00;

	// converter control status b fields
	localparam int ACC_CSB_MUX_EN = 6;
	localparam int ACC_CSB_TRIG_LSB = 0;
	localparam int ACC_CSB_TRIG_W = 3;
	localparam logic [7:0] ACC_CSB_RESET = 8'h00;

	// auxiliary control fields
	localparam int ACC_AUX_CONV_EN = 0;
	localparam int ACC_AUX_CHAN_LSB = 1;
	localparam int ACC_AUX_CHAN_W = 3;
	localparam int ACC_AUX_PWR_RED = 4;
	localparam int ACC_AUX_GIE = 5;
	localparam logic [5:0] ACC_AUX_RESET = 6'h00;

	// interrupt status and mask fields
	localparam int ACC_IRQ_W = 2;
	localparam int ACC_IRQ_EVENT = 0;
	localparam int ACC_IRQ_TOGGLE = 1;
	localparam logic [1:0] ACC_IRQ_MASK_RESET = 2'h0;
	localparam logic [1:0] ACC_IRQ_STATUS_RESET = 2'h0;

	// event mode encodings
	localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
	localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
	localparam logic [1:0] ACC_MODE_FALL = 2'h2;
	localparam logic [1:0] ACC_MODE_RISE = 2'h3;

	localparam int ACC_CHANNELS = 8;

	typedef enum logic [2:0] {
		ACC_REG_NONE,
		ACC_REG_CS,
		ACC_REG_CSB,
		ACC_REG_AUX,
		ACC_REG_STAT,
		ACC_REG_MASK
	} acc_reg_t;

	function automatic acc_reg_t acc_decode(input logic [ACC_DATA_W-1:0] addr);
		acc_reg_t r;
		r = ACC_REG_NONE;
		if (addr[ACC_DATA_W-1:ACC_IDX_LSB+ACC_IDX_W] == '0 && addr[ACC_IDX_LSB-1:0] == 2'h0)
		begin
			unique case (addr[ACC_IDX_LSB +: ACC_IDX_W])
				ACC_IDX_CMP_CS: r = ACC_REG_CS;
				ACC_IDX_CONV_CS_B: r = ACC_REG_CSB;
				ACC_IDX_AUX: r = ACC_REG_AUX;
				ACC_IDX_IRQ_STATUS: r = ACC_REG_STAT;
				ACC_IDX_IRQ_MASK: r = ACC_REG_MASK;
				default: r = ACC_REG_NONE;
			endcase
		end
		return r;
	endfunction

endpackage

// ==== acc_cmp_if.sv ====
// signals shared between the comparator front end, the synchroniser and the control core
// assumes all users sit on the system clock
interface acc_cmp_if;
	logic raw;
	logic [1:0] mode;
	logic sync_out;
	logic toggled;
	logic event_hit;
	modport front (output raw);
	modport edge_det (input raw, input mode, output sync_out, output toggled, output event_hit);
	modport ctrl (input sync_out, input toggled, input event_hit, output mode);
endinterface

// ==== acc_front.sv ====
// comparator front end: input selection and the raw comparison
// assumes analog levels arrive as unsigned codes of equal width
module acc_front
	import acc_pkg::*;
#(
	parameter int VOLT_W = 10
)
(
	input wire logic [VOLT_W-1:0] i_positive_input_pin,
	input wire logic [VOLT_W-1:0] i_negative_input_pin,
	input wire logic [ACC_CHANNELS*VOLT_W-1:0] i_converter_input_pins,
	input wire logic [VOLT_W-1:0] i_bandgap_level,
	input wire logic i_bandgap_select,
	input wire logic i_mux_route,
	input wire logic [ACC_AUX_CHAN_W-1:0] i_channel_select,
	input wire logic i_power_off,
	acc_cmp_if.front link
);
	logic [VOLT_W-1:0] pos_level;
	logic [VOLT_W-1:0] neg_level;

	always_comb
	begin
		pos_level = i_bandgap_select ? i_bandgap_level : i_positive_input_pin;
		neg_level = i_negative_input_pin;
		if (i_mux_route)
		begin
			neg_level = i_converter_input_pins[i_channel_select*VOLT_W +: VOLT_W];
		end
	end

	// an unpowered comparator yields a quiet low output
	assign link.raw = !i_power_off && (pos_level > neg_level);
endmodule

// ==== acc_edge.sv ====
// synchroniser for the raw comparator result and event detection on its output
// assumes raw may change at any moment relative to the clock
module acc_edge
	import acc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	acc_cmp_if.edge_det link
);
	logic sync_meta;
	logic sync_out;
	logic prev_out;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			sync_meta <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			sync_meta <= link.raw;
			sync_out <= sync_meta;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			prev_out <= 1'b0;
		else
			prev_out <= sync_out;
	end

	assign link.sync_out = sync_out;
	assign link.toggled = sync_out ^ prev_out;

	always_comb
	begin
		unique case (link.mode)
			ACC_MODE_TOGGLE: link.event_hit = sync_out ^ prev_out;
			ACC_MODE_RESERVED: link.event_hit = 1'b0;
			ACC_MODE_FALL: link.event_hit = prev_out && !sync_out;
			ACC_MODE_RISE: link.event_hit = sync_out && !prev_out;
		endcase
	end
endmodule

// ==== acc_top.sv ====
// analog compare control: register slave on AHB-Lite, comparator routing, event flag,
// interrupt request, capture trigger and a masked summary interrupt
// assumes single word transfers, one master and the system clock for everything
module acc_top
	import acc_pkg::*;
#(
	parameter int VOLT_W = 10,
	// arbitrary plain default for the internal reference level
	parameter logic [VOLT_W-1:0] BANDGAP_LEVEL = VOLT_W'(1) << (VOLT_W - 2)
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [ACC_DATA_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [ACC_DATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	output logic [ACC_DATA_W-1:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [VOLT_W-1:0] i_positive_input_pin,
	input wire logic [VOLT_W-1:0] i_negative_input_pin,
	input wire logic [ACC_CHANNELS*VOLT_W-1:0] i_converter_input_pins,
	input wire logic i_vector_ack,
	output logic o_compare_irq,
	output logic o_capture_trigger,
	output logic o_comparator_power_off,
	output logic o_converter_mux_lent,
	output logic [ACC_CSB_TRIG_W-1:0] o_converter_trigger_select,
	output logic o_irq
);
	if (VOLT_W < 2 || VOLT_W > 16)
	begin : g_bad_width
		$error("acc_top: VOLT_W must lie between 2 and 16");
	end

	acc_cmp_if link ();

	// control register contents
	logic power_off;
	logic bandgap_select;
	logic compare_event_flag;
	logic compare_irq_enable;
	logic capture_trigger_enable;
	logic [1:0] event_mode;
	logic comparator_mux_enable;
	logic [ACC_CSB_TRIG_W-1:0] trigger_select;
	logic converter_enable;
	logic [ACC_AUX_CHAN_W-1:0] channel_select;
	logic converter_power_reduction;
	logic global_irq_enable;
	logic [ACC_IRQ_W-1:0] irq_status;
	logic [ACC_IRQ_W-1:0] irq_mask;

	// bus pipeline
	logic dp_valid;
	logic dp_write;
	acc_reg_t dp_reg;
	acc_reg_t ap_reg;
	logic ap_take;
	logic ap_read;
	logic wr_cs;
	logic wr_csb;
	logic wr_aux;
	logic wr_mask;
	logic [7:0] wbyte;
	logic mux_route;
	logic next_flag;
	logic [ACC_IRQ_W-1:0] next_status;
	logic [ACC_IRQ_W-1:0] irq_events;
	logic [ACC_DATA_W-1:0] read_value;

	assign mux_route = comparator_mux_enable && !converter_enable;

	acc_front #(
		.VOLT_W(VOLT_W)
	) u_front (
		.i_positive_input_pin(i_positive_input_pin),
		.i_negative_input_pin(i_negative_input_pin),
		.i_converter_input_pins(i_converter_input_pins),
		.i_bandgap_level(BANDGAP_LEVEL),
		.i_bandgap_select(bandgap_select),
		.i_mux_route(mux_route),
		.i_channel_select(channel_select),
		.i_power_off(power_off),
		.link(link.front)
	);

	acc_edge u_edge (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.link(link.edge_det)
	);

	assign link.mode = event_mode;

	// address phase
	assign ap_take = i_hsel && i_hready && i_htrans[1];
	assign ap_reg = acc_decode(i_haddr);
	assign ap_read = ap_take && !i_hwrite;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_reg <= ACC_REG_NONE;
		end
		else if (i_hready)
		begin
			dp_valid <= ap_take;
			// only whole words are written; narrower writes are dropped
			dp_write <= ap_take && i_hwrite && (i_hsize == 3'h2);
			dp_reg <= ap_reg;
		end
	end

	// data phase write strobes
	assign wbyte = i_hwdata[7:0];
	assign wr_cs = dp_valid && dp_write && (dp_reg == ACC_REG_CS);
	assign wr_csb = dp_valid && dp_write && (dp_reg == ACC_REG_CSB);
	assign wr_aux = dp_valid && dp_write && (dp_reg == ACC_REG_AUX);
	assign wr_mask = dp_valid && dp_write && (dp_reg == ACC_REG_MASK);

	// ready is held low during reset; after reset the slave never stalls and never errors
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			power_off <= ACC_CS_RESET[ACC_CS_POWER_OFF];
			bandgap_select <= ACC_CS_RESET[ACC_CS_BANDGAP];
			compare_irq_enable <= ACC_CS_RESET[ACC_CS_IRQ_EN];
			capture_trigger_enable <= ACC_CS_RESET[ACC_CS_CAPTURE];
			event_mode <= ACC_CS_RESET[ACC_CS_MODE_HI:ACC_CS_MODE_LO];
		end
		else if (wr_cs)
		begin
			power_off <= wbyte[ACC_CS_POWER_OFF];
			bandgap_select <= wbyte[ACC_CS_BANDGAP];
			compare_irq_enable <= wbyte[ACC_CS_IRQ_EN];
			capture_trigger_enable <= wbyte[ACC_CS_CAPTURE];
			event_mode <= wbyte[ACC_CS_MODE_HI:ACC_CS_MODE_LO];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			comparator_mux_enable <= ACC_CSB_RESET[ACC_CSB_MUX_EN];
			trigger_select <= ACC_CSB_RESET[ACC_CSB_TRIG_LSB +: ACC_CSB_TRIG_W];
		end
		else if (wr_csb)
		begin
			comparator_mux_enable <= wbyte[ACC_CSB_MUX_EN];
			trigger_select <= wbyte[ACC_CSB_TRIG_LSB +: ACC_CSB_TRIG_W];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			converter_enable <= ACC_AUX_RESET[ACC_AUX_CONV_EN];
			channel_select <= ACC_AUX_RESET[ACC_AUX_CHAN_LSB +: ACC_AUX_CHAN_W];
			converter_power_reduction <= ACC_AUX_RESET[ACC_AUX_PWR_RED];
			global_irq_enable <= ACC_AUX_RESET[ACC_AUX_GIE];
		end
		else if (wr_aux)
		begin
			converter_enable <= wbyte[ACC_AUX_CONV_EN];
			channel_select <= wbyte[ACC_AUX_CHAN_LSB +: ACC_AUX_CHAN_W];
			// stored only; the routing does not wait for it
			converter_power_reduction <= wbyte[ACC_AUX_PWR_RED];
			global_irq_enable <= wbyte[ACC_AUX_GIE];
		end
	end

	// event flag: a new event outweighs a clear in the same cycle
	always_comb
	begin
		next_flag = compare_event_flag;
		if ((wr_cs && wbyte[ACC_CS_FLAG]) || i_vector_ack)
			next_flag = 1'b0;
		if (link.event_hit)
			next_flag = 1'b1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			compare_event_flag <= ACC_CS_RESET[ACC_CS_FLAG];
		else
			compare_event_flag <= next_flag;
	end

	// sticky interrupt status, cleared by reading it
	always_comb
	begin
		irq_events = '0;
		irq_events[ACC_IRQ_EVENT] = link.event_hit;
		irq_events[ACC_IRQ_TOGGLE] = link.toggled;
		next_status = irq_status;
		if (ap_read && ap_reg == ACC_REG_STAT)
			next_status = '0;
		next_status = next_status | irq_events;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			irq_status <= ACC_IRQ_STATUS_RESET;
		else
			irq_status <= next_status;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			irq_mask <= ACC_IRQ_MASK_RESET;
		else if (wr_mask)
			irq_mask <= wbyte[ACC_IRQ_W-1:0];
	end

	// read data is prepared in the address phase so it leaves a flop
	always_comb
	begin
		read_value = '0;
		unique case (ap_reg)
			ACC_REG_CS:
			begin
				read_value[ACC_CS_POWER_OFF] = power_off;
				read_value[ACC_CS_BANDGAP] = bandgap_select;
				read_value[ACC_CS_OUT] = link.sync_out;
				read_value[ACC_CS_FLAG] = compare_event_flag;
				read_value[ACC_CS_IRQ_EN] = compare_irq_enable;
				read_value[ACC_CS_CAPTURE] = capture_trigger_enable;
				read_value[ACC_CS_MODE_HI:ACC_CS_MODE_LO] = event_mode;
			end
			ACC_REG_CSB:
			begin
				read_value[ACC_CSB_MUX_EN] = comparator_mux_enable;
				read_value[ACC_CSB_TRIG_LSB +: ACC_CSB_TRIG_W] = trigger_select;
			end
			ACC_REG_AUX:
			begin
				read_value[ACC_AUX_CONV_EN] = converter_enable;
				read_value[ACC_AUX_CHAN_LSB +: ACC_AUX_CHAN_W] = channel_select;
				read_value[ACC_AUX_PWR_RED] = converter_power_reduction;
				read_value[ACC_AUX_GIE] = global_irq_enable;
			end
			ACC_REG_STAT: read_value[ACC_IRQ_W-1:0] = irq_status;
			ACC_REG_MASK: read_value[ACC_IRQ_W-1:0] = irq_mask;
			ACC_REG_NONE: read_value = '0;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_hrdata <= '0;
		else if (ap_read)
			o_hrdata <= read_value;
	end

	// request trails the flag by one cycle
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_compare_irq <= 1'b0;
		else
			o_compare_irq <= compare_event_flag && compare_irq_enable && global_irq_enable;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_capture_trigger <= 1'b0;
		else
			o_capture_trigger <= capture_trigger_enable && link.sync_out;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_status & irq_mask);
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_comparator_power_off <= 1'b0;
			o_converter_mux_lent <= 1'b0;
			o_converter_trigger_select <= '0;
		end
		else
		begin
			o_comparator_power_off <= power_off;
			// tells the converter its multiplexer serves the comparator
			o_converter_mux_lent <= mux_route;
			o_converter_trigger_select <= trigger_select;
		end
	end
endmodule

// ==== acc_top_assertions.sv ====
// port-level checks of the analog compare control block
// assumes word transfers, zero wait states and registers at four times their index
module acc_top_assertions
	import acc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [ACC_DATA_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [ACC_DATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [ACC_DATA_W-1:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_capture_trigger,
	input wire logic o_comparator_power_off,
	input wire logic [ACC_CSB_TRIG_W-1:0] o_converter_trigger_select
);
	localparam logic [31:0] A_CS = 32'(ACC_IDX_CMP_CS) << 2;
	localparam logic [31:0] A_CSB = 32'(ACC_IDX_CONV_CS_B) << 2;
	logic take;
	logic mapped;
	logic wr_cs_q, wr_cs_qq, wr_csb_q, wr_csb_qq, pwr_d;
	logic [2:0] trig_d;
	assign take = i_hsel && i_hready && i_htrans[1];
	assign mapped = i_haddr inside {A_CS, A_CSB, 32'h1c0, 32'h1c4, 32'h1c8};

	// remember a word write until its data phase has been taken
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			wr_cs_q <= 1'b0;
			wr_cs_qq <= 1'b0;
			wr_csb_q <= 1'b0;
			wr_csb_qq <= 1'b0;
		end
		else
		begin
			wr_cs_q <= take && i_hwrite && i_hsize == 3'h2 && i_haddr == A_CS;
			wr_csb_q <= take && i_hwrite && i_hsize == 3'h2 && i_haddr == A_CSB;
			wr_cs_qq <= wr_cs_q;
			wr_csb_qq <= wr_csb_q;
		end
	end
	always_ff @(posedge i_clock)
	begin
		if (wr_cs_q)
			pwr_d <= i_hwdata[ACC_CS_POWER_OFF];
		if (wr_csb_q)
			trig_d <= i_hwdata[2:0];
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_rd_cs;
		take && !i_hwrite && i_haddr == A_CS;
	endsequence
	sequence s_rd_unmapped;
		take && !i_hwrite && !mapped;
	endsequence

	a_resp_okay: assert property (!o_hresp) else $error("response not okay");
	a_ready_after_reset: assert property ($past(i_rst_n) |-> o_hreadyout)
		else $error("ready low after reset");
	a_rdata_upper_zero: assert property (take && !i_hwrite |=> o_hrdata[31:8] == 24'h0)
		else $error("upper read bytes not zero");
	a_unmapped_zero: assert property (s_rd_unmapped |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_power_follows: assert property (wr_cs_qq |-> ##[0:1] o_comparator_power_off == pwr_d)
		else $error("power-off output not written value");
	a_power_quiet: assert property (o_comparator_power_off [*4] |-> !o_capture_trigger)
		else $error("trigger while powered off");
	a_capture_match: assert property (s_rd_cs |=> o_capture_trigger == (o_hrdata[2] && o_hrdata[5]))
		else $error("capture trigger differs from output");
	a_trigsel_follows: assert property (wr_csb_qq |-> ##[0:1] o_converter_trigger_select == trig_d)
		else $error("trigger select not written value");
endmodule
bind acc_top acc_top_assertions acc_top_assertions_inst(.i_clock, .i_rst_n, .i_hsel, .i_haddr,
	.i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
	.o_capture_trigger, .o_comparator_power_off, .o_converter_trigger_select);

// ==== analog_compare_control_bench.sv ====
// self-checking bench of the analog compare control block
// assumes the bandgap level is set to 256 here and zero wait states are not relied on
module analog_compare_control_bench
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CS = 32'h140, CSB = 32'h1ec, AUX = 32'h1c0, ST = 32'h1c4, MK = 32'h1c8;
	typedef struct {logic [31:0] csb, aux, cs; logic [9:0] p, n; logic [2:0] lo; logic e;} acc_row_t;
	logic i_clock = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0, i_vector_ack = 0;
	logic [31:0] i_haddr = 0, i_hwdata = 0, rd;
	logic [1:0] i_htrans = 0;
	logic [2:0] i_hsize = 0;
	logic [9:0] i_positive_input_pin = 0, i_negative_input_pin = 0;
	logic [79:0] i_converter_input_pins = 0;
	logic [31:0] o_hrdata;
	logic o_hreadyout, o_hresp, o_compare_irq, o_capture_trigger, o_comparator_power_off;
	logic o_converter_mux_lent, o_irq;
	logic [2:0] o_converter_trigger_select;
	int n_mismatch = 0, compares = 0;
	acc_row_t rows[13];

	always #20 i_clock = ~i_clock;

	acc_top #(.VOLT_W(10), .BANDGAP_LEVEL(10'd256)) acc_top_inst(.i_clock, .i_rst_n, .i_hsel,
		.i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
		.o_hreadyout, .o_hresp, .i_positive_input_pin, .i_negative_input_pin,
		.i_converter_input_pins, .i_vector_ack, .o_compare_irq, .o_capture_trigger,
		.o_comparator_power_off, .o_converter_mux_lent, .o_converter_trigger_select, .o_irq);

	task results;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("Error at %0t got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	// ready is a registered level, so its value between edges is what the next edge samples
	task hw;
		int k;
		k = 0;
		@(negedge i_clock);
		while (o_hreadyout !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				n_mismatch++;
				results();
			end
			@(negedge i_clock);
		end
		rd = o_hrdata;
		@(posedge i_clock);
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_haddr <= a;
		i_hwrite <= w;
		i_hsize <= 3'h2;
		i_htrans <= 2'h2;
		hw();
		i_htrans <= 2'h0;
		i_hsel <= 1'b0;
		i_hwdata <= d;
		hw();
	endtask
	task rdc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task pins(input logic [9:0] p, input logic [9:0] n, input logic [2:0] lo);
		i_positive_input_pin <= p;
		i_negative_input_pin <= n;
		for (int c = 0; c < 8; c++)
			i_converter_input_pins[c*10 +: 10] <= (c == lo) ? 10'd100 : 10'd900;
		repeat (5) @(posedge i_clock);
	endtask
	task vec;
		i_vector_ack <= 1'b1;
		@(posedge i_clock);
		i_vector_ack <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask

	initial
	begin
		rows[0] = '{32'h0, 32'h0, 32'h0, 10'd300, 10'd200, 3'h0, 1'b1};
		rows[1] = '{32'h0, 32'h0, 32'h0, 10'd100, 10'd200, 3'h0, 1'b0};
		for (int c = 0; c < 8; c++)
			rows[2+c] = '{32'h40, 32'(c) << 1, 32'h0, 10'd300, 10'd800, 3'(c), 1'b1};
		rows[10] = '{32'h40, 32'h05, 32'h0, 10'd300, 10'd800, 3'h2, 1'b0};
		rows[11] = '{32'h0, 32'h0, 32'h40, 10'd0, 10'd100, 3'h0, 1'b1};
		rows[12] = '{32'h0, 32'h0, 32'h40, 10'd900, 10'd300, 3'h0, 1'b0};
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		rdc(CS, 32'h0);
		rdc(CSB, 32'h0);
		rdc(AUX, 32'h0);
		rdc(MK, 32'h0);
		rdc(32'h1000, 32'h0);
		bus(1'b1, CSB, 32'hffffff47);
		rdc(CSB, 32'h47);
		chk(32'(o_converter_trigger_select), 32'h7);
		for (int i = 0; i < 13; i++)
		begin
			bus(1'b1, CSB, rows[i].csb);
			bus(1'b1, AUX, rows[i].aux);
			bus(1'b1, CS, rows[i].cs);
			pins(rows[i].p, rows[i].n, rows[i].lo);
			bus(1'b0, CS, 32'h0);
			chk(32'(rd[5]), 32'(rows[i].e));
			chk(32'(o_converter_mux_lent), 32'(rows[i].csb[6] && !rows[i].aux[0]));
		end
		bus(1'b1, CSB, 32'h0);
		bus(1'b1, AUX, 32'h0);
		pins(10'd0, 10'd500, 3'h0);
		for (int m = 0; m < 4; m++)
		begin
			bus(1'b1, CS, 32'h10 | m);
			pins(10'd600, 10'd500, 3'h0);
			bus(1'b0, CS, 32'h0);
			chk(32'(rd[4]), 32'(m == 0 || m == 3));
			bus(1'b1, CS, 32'h10 | m);
			pins(10'd0, 10'd500, 3'h0);
			bus(1'b0, CS, 32'h0);
			chk(32'(rd[4]), 32'(m == 0 || m == 2));
		end
		// rising output in rise mode sets the flag, so a zero write has something to keep
		pins(10'd600, 10'd500, 3'h0);
		bus(1'b1, CS, 32'h0);
		rdc(CS, 32'h30);
		bus(1'b1, CS, 32'h10);
		rdc(CS, 32'h20);
		pins(10'd0, 10'd500, 3'h0);
		bus(1'b0, ST, 32'h0);
		bus(1'b1, MK, 32'h3);
		bus(1'b1, AUX, 32'h20);
		bus(1'b1, CS, 32'h1f);
		pins(10'd600, 10'd500, 3'h0);
		chk(32'(o_compare_irq), 32'h1);
		chk(32'(o_capture_trigger), 32'h1);
		chk(32'(o_irq), 32'h1);
		rdc(ST, 32'h3);
		rdc(ST, 32'h0);
		repeat (2) @(posedge i_clock);
		chk(32'(o_irq), 32'h0);
		bus(1'b1, AUX, 32'h0);
		repeat (3) @(posedge i_clock);
		chk(32'(o_compare_irq), 32'h0);
		bus(1'b1, AUX, 32'h20);
		repeat (3) @(posedge i_clock);
		chk(32'(o_compare_irq), 32'h1);
		vec();
		chk(32'(o_compare_irq), 32'h0);
		rdc(CS, 32'h2f);
		bus(1'b1, CS, 32'h13);
		bus(1'b1, MK, 32'h0);
		pins(10'd0, 10'd500, 3'h0);
		chk(32'(o_capture_trigger), 32'h0);
		chk(32'(o_irq), 32'h0);
		rdc(ST, 32'h2);
		pins(10'd600, 10'd500, 3'h0);
		bus(1'b1, CS, 32'h93);
		repeat (5) @(posedge i_clock);
		chk(32'(o_comparator_power_off), 32'h1);
		rdc(CS, 32'h83);
		// reset in mid-run must bring the registers and outputs back to zero
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		chk(32'(o_comparator_power_off), 32'h0);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		rdc(AUX, 32'h0);
		results();
	end
endmodule
